//--- inc/conv_pkg.sv
// Shared constants, register map and carrier types of the convolutional encoder.
`default_nettype none
package conv_pkg;

  // Bus and datapath widths.
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int K_MAX = 12;
  localparam int STATE_W = 11;
  localparam int TAPS = 8;
  localparam int BLK_MAX = 12;
  localparam int OUT_W = 8;
  localparam int CNT_W = 16;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_IDLE = 8'h08;
  localparam logic [ADR_W-1:0] REG_KEEP_FIRST = 8'h0c;
  localparam logic [ADR_W-1:0] REG_KEEP_SECOND = 8'h10;
  localparam logic [2:0] TAP_PAGE = 3'h1;

  // Control word fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PUNCT_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int CTRL_K_LSB = 4;
  localparam int CTRL_IN_RATE_LSB = 8;
  localparam int CTRL_OUT_RATE_LSB = 16;

  // Status word fields.
  localparam int STATUS_READY_BIT = 0;
  localparam int STATUS_FULL_BIT = 1;
  localparam int STATUS_POS_LSB = 4;
  localparam int STATUS_COUNT_LSB = 16;

  // Legal configuration ranges.
  localparam logic [4:0] K_LO = 5'h03;
  localparam logic [4:0] K_HI = 5'h0c;
  localparam logic [4:0] IN_RATE_LO = 5'h02;
  localparam logic [4:0] IN_RATE_HI = 5'h0c;
  localparam logic [4:0] OUT_RATE_LO = 5'h02;
  localparam logic [4:0] OUT_RATE_HI = 5'h08;

  // Reset values: rate 1/2, constraint length 7, octal taps 171 and 133.
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_PUNCT = 1'b0;
  localparam logic [3:0] RST_K = 4'h7;
  localparam logic [3:0] RST_IN_RATE = 4'h2;
  localparam logic [4:0] RST_OUT_RATE = 5'h02;
  localparam logic [K_MAX-1:0] RST_TAP0 = 12'h079;
  localparam logic [K_MAX-1:0] RST_TAP1 = 12'h05b;
  localparam logic [K_MAX-1:0] RST_TAP_OTHER = 12'h000;
  localparam logic [BLK_MAX-1:0] RST_KEEP_FIRST = 12'h003;
  localparam logic [BLK_MAX-1:0] RST_KEEP_SECOND = 12'h001;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_s;

  // One encoder position handed to the puncture unit.
  typedef struct packed {
    logic load;
    logic bit_first;
    logic bit_second;
    logic keep_first;
    logic keep_second;
    logic block_start;
  } pair_s;

  typedef struct packed {
    logic valid;
    logic first;
    logic data;
  } punct_out_s;

endpackage
`default_nettype wire

//--- core/punct_unit.sv
// Puncture unit: serialises the kept bits of each rate-1/2 position, one bit per cycle.
`timescale 1ns/1ps
`default_nettype none
module punct_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire conv_pkg::pair_s pair,
  output logic can_load,
  output conv_pkg::punct_out_s pout
);
  import conv_pkg::*;

  typedef struct packed {
    logic have_first;
    logic have_second;
    logic b_first;
    logic b_second;
    logic first_pend;
    punct_out_s out;
  } pu_s;

  localparam pu_s PU_INIT = '0;

  pu_s r;
  pu_s next_r;

  // A slot with one bit left empties this cycle, so it may be refilled now.
  assign can_load = ~(r.have_first & r.have_second);
  assign pout = r.out;

  always_comb begin
    next_r = r;
    next_r.out.valid = 1'b0;
    next_r.out.first = 1'b0;
    if (r.have_first) begin
      next_r.out.valid = 1'b1;
      next_r.out.data = r.b_first;
      next_r.out.first = r.first_pend;
      next_r.first_pend = 1'b0;
      next_r.have_first = 1'b0;
    end else if (r.have_second) begin
      next_r.out.valid = 1'b1;
      next_r.out.data = r.b_second;
      next_r.out.first = r.first_pend;
      next_r.first_pend = 1'b0;
      next_r.have_second = 1'b0;
    end
    // The source only loads while can_load is high, so nothing is lost here.
    if (pair.load) begin
      next_r.have_first = pair.keep_first;
      next_r.have_second = pair.keep_second;
      next_r.b_first = pair.bit_first;
      next_r.b_second = pair.bit_second;
      // Set wins over the clear above; a block whose first position keeps
      // nothing marks the next bit that is actually sent.
      next_r.first_pend = pair.block_start | next_r.first_pend;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= PU_INIT;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

//--- core/conv_encoder_puncture.sv
// Convolutional encoder with optional puncturing and a Wishbone register file.
//
// How it works
// - One clock at the symbol rate; at most one input bit per cycle.
// - Asynchronous active-low reset returns the whole core to its reset values.
// - Bits offered while input_ready is low are ignored.
// - Idle cycles with input_ready high drain the puncture slot and are counted.
// - block_first_flag marks the first sent bit of each punctured block.
// - coded_out_valid is high exactly when coded_out carries data.
// - Output is rate bits wide unpunctured, one bit punctured.
// - Each coded bit is the XOR of taps; tap MSB is current input.
// - Constraint length is configurable from 3 to 12.
// - Input rate is 1 unpunctured, 2 to 12 punctured, setting block size.
// - Output rate 2 to 8 unpunctured, 3 to 23 punctured; punctured rate is set only by the keep masks and is not checked.
// - Unpunctured uses rate tap patterns; punctured uses exactly two.
// - Punctured mode encodes at rate 1/2, then punctures to one channel.
// - Two keep masks, one per channel, as long as the block.
// - Control derives the handshakes and stalls input on rate mismatch.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module conv_encoder_puncture (
  input wire logic clk,
  input wire logic resetn,
  input wire conv_pkg::wb_req_s wb_req,
  output conv_pkg::wb_rsp_s wb_rsp,
  input wire logic din_valid,
  input wire logic din,
  output logic input_ready,
  output logic [conv_pkg::OUT_W-1:0] coded_out,
  output logic coded_out_valid,
  output logic block_first_flag
);
  import conv_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdata;
    logic enable;
    logic punct;
    logic [3:0] k;
    logic [3:0] in_rate;
    logic [4:0] out_rate;
    logic [BLK_MAX-1:0] keep_first;
    logic [BLK_MAX-1:0] keep_second;
    logic [TAPS-1:0][K_MAX-1:0] tap;
    logic [STATE_W-1:0] shift;
    logic [3:0] pos;
    logic [OUT_W-1:0] np_data;
    logic np_valid;
    logic [CNT_W-1:0] accepted;
    logic [CNT_W-1:0] idle;
  } enc_s;

  localparam enc_s ENC_INIT = '{
    ack: 1'b0,
    rdata: '0,
    enable: RST_ENABLE,
    punct: RST_PUNCT,
    k: RST_K,
    in_rate: RST_IN_RATE,
    out_rate: RST_OUT_RATE,
    keep_first: RST_KEEP_FIRST,
    keep_second: RST_KEEP_SECOND,
    tap: {{(TAPS-2){RST_TAP_OTHER}}, RST_TAP1, RST_TAP0},
    shift: '0,
    pos: '0,
    np_data: '0,
    np_valid: 1'b0,
    accepted: '0,
    idle: '0
  };

  // Keeps a configuration field inside its legal range.
  function automatic logic [4:0] clamp(input logic [4:0] v,
                                       input logic [4:0] lo,
                                       input logic [4:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Parity of the current input and the stored past inputs under a tap
  // pattern; bit k-1 of the pattern is the current input, bit 0 the oldest.
  function automatic logic code_bit(input logic [K_MAX-1:0] pat,
                                    input logic d,
                                    input logic [STATE_W-1:0] s,
                                    input logic [3:0] k);
    logic [K_MAX-1:0] win;
    logic [K_MAX:0] lim;
    win = {1'b0, s} | (K_MAX'(d) << (k - 4'h1));
    lim = ((K_MAX + 1)'(1) << k) - (K_MAX + 1)'(1);
    return ^(pat & win & lim[K_MAX-1:0]);
  endfunction

  // Shifts the new bit into position k-2; older bits move towards bit 0.
  function automatic logic [STATE_W-1:0] shift_in(
    input logic [STATE_W-1:0] s,
    input logic d,
    input logic [3:0] k
  );
    logic [STATE_W-1:0] o;
    o = '0;
    for (int i = 0; i < STATE_W; i++) begin
      if (i == int'(k) - 2) begin
        o[i] = d;
      end else if ((i < int'(k) - 2) && (i < STATE_W - 1)) begin
        o[i] = s[i+1];
      end
    end
    return o;
  endfunction

  // Applies Wishbone byte selects to a register word.
  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old,
                                             input logic [DAT_W-1:0] nw,
                                             input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] o;
    o = old;
    for (int b = 0; b < SEL_W; b++) begin
      if (sel[b]) begin
        o[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return o;
  endfunction

  enc_s r;
  enc_s next_r;
  pair_s pair;
  punct_out_s pout;
  logic pu_can_load;
  logic accept;
  logic [3:0] k_eff;
  logic [3:0] in_eff;
  logic [4:0] np_rate;
  logic [DAT_W-1:0] ctrl_word;
  logic [DAT_W-1:0] status_word;
  logic [DAT_W-1:0] wword;
  logic bus_req;
  logic bus_write;

  punct_unit u_punct (
    .clk(clk),
    .resetn(resetn),
    .pair(pair),
    .can_load(pu_can_load),
    .pout(pout)
  );

  // Enabled unpunctured streams never stall; punctured ones stall while the slot
  // still holds two kept bits, because only one bit leaves per cycle.
  assign input_ready = r.enable & (~r.punct | pu_can_load);
  assign accept = din_valid & input_ready;
  assign k_eff = 4'(clamp({1'b0, r.k}, K_LO, K_HI));
  assign in_eff = 4'(clamp({1'b0, r.in_rate}, IN_RATE_LO, IN_RATE_HI));
  assign np_rate = clamp(r.out_rate, OUT_RATE_LO, OUT_RATE_HI);
  assign bus_req = wb_req.cyc & wb_req.stb;
  assign bus_write = bus_req & r.ack & wb_req.we;

  // Punctured mode always runs the two-pattern rate-1/2 encoder.
  always_comb begin
    pair.load = accept & r.punct;
    pair.bit_first = code_bit(r.tap[0], din, r.shift, k_eff);
    pair.bit_second = code_bit(r.tap[1], din, r.shift, k_eff);
    pair.keep_first = r.keep_first[r.pos];
    pair.keep_second = r.keep_second[r.pos];
    pair.block_start = (r.pos == 4'h0);
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_ENABLE_BIT] = r.enable;
    ctrl_word[CTRL_PUNCT_BIT] = r.punct;
    ctrl_word[CTRL_K_LSB +: 4] = r.k;
    ctrl_word[CTRL_IN_RATE_LSB +: 4] = r.in_rate;
    ctrl_word[CTRL_OUT_RATE_LSB +: 5] = r.out_rate;
    status_word = '0;
    status_word[STATUS_READY_BIT] = input_ready;
    status_word[STATUS_FULL_BIT] = ~pu_can_load;
    status_word[STATUS_POS_LSB +: 4] = r.pos;
    status_word[STATUS_COUNT_LSB +: CNT_W] = r.accepted;
  end

  always_comb begin
    next_r = r;
    wword = '0;

    // Streaming datapath.
    next_r.np_valid = accept & ~r.punct;
    if (accept & ~r.punct) begin
      for (int t = 0; t < TAPS; t++) begin
        if (t < int'(np_rate)) begin
          next_r.np_data[t] = code_bit(r.tap[t], din, r.shift, k_eff);
        end else begin
          next_r.np_data[t] = 1'b0;
        end
      end
    end
    if (accept) begin
      next_r.shift = shift_in(r.shift, din, k_eff);
      next_r.accepted = r.accepted + CNT_W'(1);
    end
    if (accept & r.punct) begin
      if (r.pos >= in_eff - 4'h1) begin
        next_r.pos = 4'h0;
      end else begin
        next_r.pos = r.pos + 4'h1;
      end
    end
    if (input_ready & ~din_valid) begin
      next_r.idle = r.idle + CNT_W'(1);
    end

    // Wishbone classic slave: ack one cycle after the strobe, dropped next.
    next_r.ack = bus_req & ~r.ack;
    if (bus_req & ~r.ack) begin
      if (wb_req.adr == REG_CTRL) begin
        next_r.rdata = ctrl_word;
      end else if (wb_req.adr == REG_STATUS) begin
        next_r.rdata = status_word;
      end else if (wb_req.adr == REG_IDLE) begin
        next_r.rdata = DAT_W'(r.idle);
      end else if (wb_req.adr == REG_KEEP_FIRST) begin
        next_r.rdata = DAT_W'(r.keep_first);
      end else if (wb_req.adr == REG_KEEP_SECOND) begin
        next_r.rdata = DAT_W'(r.keep_second);
      end else if (wb_req.adr[7:5] == TAP_PAGE) begin
        next_r.rdata = DAT_W'(r.tap[wb_req.adr[4:2]]);
      end else begin
        next_r.rdata = '0;
      end
    end

    // Writes land at the edge on which the master sees ack.
    if (bus_write) begin
      if (wb_req.adr == REG_CTRL) begin
        wword = merge(ctrl_word, wb_req.dat, wb_req.sel);
        next_r.enable = wword[CTRL_ENABLE_BIT];
        next_r.punct = wword[CTRL_PUNCT_BIT];
        next_r.k = wword[CTRL_K_LSB +: 4];
        next_r.in_rate = wword[CTRL_IN_RATE_LSB +: 4];
        next_r.out_rate = wword[CTRL_OUT_RATE_LSB +: 5];
        // Restart wins over a bit accepted in the same cycle.
        if (wword[CTRL_RESTART_BIT]) begin
          next_r.shift = '0;
          next_r.pos = 4'h0;
        end
      end else if (wb_req.adr == REG_IDLE) begin
        next_r.idle = '0;
      end else if (wb_req.adr == REG_KEEP_FIRST) begin
        wword = merge(DAT_W'(r.keep_first), wb_req.dat, wb_req.sel);
        next_r.keep_first = wword[BLK_MAX-1:0];
      end else if (wb_req.adr == REG_KEEP_SECOND) begin
        wword = merge(DAT_W'(r.keep_second), wb_req.dat, wb_req.sel);
        next_r.keep_second = wword[BLK_MAX-1:0];
      end else if (wb_req.adr[7:5] == TAP_PAGE) begin
        wword = merge(DAT_W'(r.tap[wb_req.adr[4:2]]), wb_req.dat,
                      wb_req.sel);
        next_r.tap[wb_req.adr[4:2]] = wword[K_MAX-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= ENC_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign wb_rsp = '{ack: r.ack, dat: r.rdata};

  // Switching mode mid-stream is not guarded; software should restart.
  always_comb begin
    if (r.punct) begin
      coded_out = {{(OUT_W-1){1'b0}}, pout.data};
      coded_out_valid = pout.valid;
      block_first_flag = pout.first;
    end else begin
      coded_out = r.np_data;
      coded_out_valid = r.np_valid;
      block_first_flag = 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- testbench/bit_source.sv
// Upstream bit source that offers random bits with random idle gaps.
`timescale 1ns/1ps
`default_nettype none
module bit_source (
  input wire logic clk,
  input wire logic run,
  input wire logic blind,
  input wire logic input_ready,
  output logic din_valid,
  output logic din
);
  int seed = 32'h1e1b905b;
  logic offer = 1'b0;
  // Gaps are left on purpose so the core can use them for rate matching.
  always @(posedge clk) begin
    offer <= run && ($random(seed) % 4 != 0);
    din <= 1'($random(seed));
  end
  // Blind mode is the one commanded misbehaviour: offering while not ready.
  assign din_valid = offer & (input_ready | blind);
endmodule
`default_nettype wire

//--- testbench/conv_encoder_chk.sv
// Port-level temporal checks of the convolutional encoder.
`timescale 1ns/1ps
`default_nettype none
module conv_encoder_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire conv_pkg::wb_req_s wb_req,
  input wire conv_pkg::wb_rsp_s wb_rsp,
  input wire logic din_valid,
  input wire logic din,
  input wire logic input_ready,
  input wire logic [conv_pkg::OUT_W-1:0] coded_out,
  input wire logic coded_out_valid,
  input wire logic block_first_flag
);
  import conv_pkg::*;
  wire logic take = din_valid & input_ready;
  wire logic req = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stood longer than one cycle");
  ack_reply_a: assert property (req |=> wb_rsp.ack)
    else $error("bus request not answered in one cycle");
  reset_quiet_a: assert property ($rose(resetn) |->
    !coded_out_valid && !block_first_flag)
    else $error("output flags high after reset");
  first_valid_a: assert property (block_first_flag |-> coded_out_valid)
    else $error("block start flag without valid output");
  first_width_a: assert property (block_first_flag |->
    coded_out[OUT_W-1:1] == 7'h00)
    else $error("punctured output wider than one bit");
  out_cause_a: assert property (coded_out_valid |->
    $past(take) || $past(take, 2) || $past(take, 3))
    else $error("output valid without a recent accepted bit");
  ready_fall_a: assert property ($fell(input_ready) |->
    $past(take) || $past(wb_rsp.ack))
    else $error("ready dropped with no cause");
  first_gap_a: assert property (block_first_flag |=> !block_first_flag)
    else $error("block start flag on two cycles in a row");
  cover property (block_first_flag);
  cover property ($fell(input_ready));
  cover property (req && wb_req.we);
endmodule
bind conv_encoder_puncture conv_encoder_chk u_conv_encoder_chk (
  .clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .din_valid(din_valid), .din(din), .input_ready(input_ready),
  .coded_out(coded_out), .coded_out_valid(coded_out_valid),
  .block_first_flag(block_first_flag));
`default_nettype wire

//--- testbench/conv_encoder_puncture_tb.sv
// Self-checking bench: bit-level encoder model compared with the core.
`timescale 1ns/1ps
`default_nettype none
module conv_encoder_puncture_tb;
  import conv_pkg::*;
  logic clk, resetn, run, blind, din_valid, din, input_ready;
  logic coded_out_valid, block_first_flag, nf;
  logic [OUT_W-1:0] coded_out;
  wb_req_s wb_req;
  wb_rsp_s wb_rsp;
  int failures, comparisons, seed = 32'h1e1b905b;
  int k, inr, outr, pm, pos, idle_n, acc_n, snap_idle, snap_acc;
  logic [11:0] tap [8];
  logic [11:0] kf, ks, sr, wv;
  logic [8:0] expq [$];
  logic [31:0] rd;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h28, 8'h0c, 8'h10,
    8'hfc};
  logic [31:0] rv [8] = '{32'h00020271, 32'h1, 32'h079, 32'h05b, 32'h0,
    32'h003, 32'h001, 32'h0};

  conv_encoder_puncture u_conv_encoder_puncture (.clk(clk), .resetn(resetn),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .din_valid(din_valid), .din(din),
    .input_ready(input_ready), .coded_out(coded_out),
    .coded_out_valid(coded_out_valid), .block_first_flag(block_first_flag));
  bit_source u_bit_source (.clk(clk), .run(run), .blind(blind),
    .input_ready(input_ready), .din_valid(din_valid), .din(din));

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1);
    check("ack delay", n, 2);
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk);
  endtask

  // Window holds the current bit at k-1 and the older bits below it.
  task automatic encode(input logic d);
    logic [7:0] o = 8'h00;
    wv = ({11'h0, d} << (k - 1)) | sr;
    sr = wv >> 1;
    if (pm == 0) begin
      for (int i = 0; i < outr; i++) o[i] = ^(tap[i] & wv);
      expq.push_back({1'b0, o});
    end else begin
      if (pos == 0) nf = 1'b1;
      if (kf[pos]) begin
        expq.push_back({nf, 7'h0, ^(tap[0] & wv)});
        nf = 1'b0;
      end
      if (ks[pos]) begin
        expq.push_back({nf, 7'h0, ^(tap[1] & wv)});
        nf = 1'b0;
      end
      pos = (pos + 1) % inr;
    end
  endtask

  always @(posedge clk) begin
    if (resetn !== 1'b1) begin
      sr = 0;
      pos = 0;
      idle_n = 0;
      acc_n = 0;
    end else begin
      if (wb_req.cyc && wb_req.stb && wb_rsp.ack !== 1'b1) begin
        snap_idle = idle_n;
        snap_acc = acc_n;
      end
      if (coded_out_valid === 1'b1) begin
        if (expq.size() == 0) check("spare output", 1, 0);
        else check("coded_out", {block_first_flag, coded_out},
          expq.pop_front());
      end
      if (input_ready === 1'b1 && din_valid === 1'b0) idle_n++;
      if (input_ready === 1'b1 && din_valid === 1'b1) begin
        acc_n++;
        encode(din);
      end
      if (wb_rsp.ack === 1'b1 && wb_req.we && wb_req.adr == REG_IDLE)
        idle_n = 0;
    end
  end

  task automatic cfg(input int p, kk, ir, orr);
    int n = 0;
    run <= 1'b0;
    while (expq.size() > 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("pending outputs", expq.size(), 0);
    k = kk;
    inr = ir;
    outr = orr;
    pm = p;
    for (int i = 0; i < 8; i++) begin
      tap[i] = 12'($random(seed));
      wb(1, 8'h20 + 8'(4 * i), {20'h0, tap[i]});
    end
    kf = 12'($random(seed)) & 12'((1 << ir) - 1);
    ks = 12'($random(seed)) & 12'((1 << ir) - 1);
    wb(1, REG_KEEP_FIRST, {20'h0, kf});
    wb(1, REG_KEEP_SECOND, {20'h0, ks});
    wb(1, REG_CTRL, (orr << 16) | (ir << 8) | (kk << 4) | (p << 1) | 5);
    sr = 0;
    pos = 0;
    run <= 1'b1;
    repeat (80) @(posedge clk);
    run <= 1'b0;
    wb(0, REG_STATUS, 0);
    check("accepted count", rd[31:16], 16'(snap_acc));
    wb(0, REG_IDLE, 0);
    check("idle count", rd[15:0], 16'(snap_idle));
    wb(1, REG_IDLE, 0);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    resetn = 1'b0;
    run = 1'b0;
    blind = 1'b0;
    wb_req = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) begin
      wb(0, ra[i], 0);
      check("reset register", rd, rv[i]);
    end
    for (int r = 2; r <= 8; r++) cfg(0, 3 + (r * 7) % 10, 2, r);
    for (int j = 0; j < 6; j++)
      cfg(1, 3 + (j * 5) % 10, (j == 0) ? 12 : 2 + (j * 3) % 11, 0);
    wb(1, REG_CTRL, 32'h00020270);
    blind <= 1'b1;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    check("ready when off", input_ready, 0);
    run <= 1'b0;
    blind <= 1'b0;
    wb(0, REG_STATUS, 0);
    check("count when off", rd[31:16], 16'(snap_acc));
    check("outputs left", expq.size(), 0);
    results();
  end
endmodule
`default_nettype wire
